// file: design/pef_pkg.sv
// constants, register map and field layout of the protection event flag block
// assumes an axi4-lite master with 32-bit data and a core that pulses on entry and return
package pef_pkg;
	localparam int ADDR_W = 12;

	localparam logic [ADDR_W-1:0] OFF_FLAGS  = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_SEL    = 12'h008;
	localparam logic [ADDR_W-1:0] OFF_CTRL   = 12'h00C;
	localparam logic [ADDR_W-1:0] OFF_STACK  = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_SP     = 12'h014;
	localparam logic [ADDR_W-1:0] OFF_MEM    = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_MEM_END = 12'h140;

	localparam logic [7:0] FLAG_IMPL = 8'h9F;
	localparam logic [7:0] RST_BYTE  = 8'h00;

	localparam int FB_SAT  = 7;
	localparam int FB_OT   = 4;
	localparam int FB_OOV  = 3;
	localparam int FB_GATE = 2;
	localparam int FB_IOV  = 1;
	localparam int FB_IUV  = 0;

	localparam int SB_IUV_R = 0;
	localparam int SB_IUV_F = 1;
	localparam int SB_IOV_R = 2;
	localparam int SB_IOV_F = 3;
	localparam int SB_OOV_R = 4;
	localparam int SB_OOV_F = 5;

	localparam int CB_PERIPH = 0;
	localparam int CB_GLOBAL = 1;

	localparam int MEM_IDX_LSB = 2;
	localparam int MEM_IDX_W   = 4;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: design/pef_top.sv
// protection event flags, their enables, edge selects, pc stack and shared data bytes
// assumes comparator inputs are asynchronous and core strobes share aclk
//
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pef_top #(
	parameter int PC_W    = 13,
	parameter int STK_D   = 8,
	parameter int MEM_D   = 16
) (
	input  wire  logic                       aclk,
	input  wire  logic                       aresetn,
	input  wire  logic [pef_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire  logic                       s_axi_awvalid,
	output var   logic                       s_axi_awready,
	input  wire  logic [31:0]                s_axi_wdata,
	input  wire  logic [3:0]                 s_axi_wstrb,
	input  wire  logic                       s_axi_wvalid,
	output var   logic                       s_axi_wready,
	output var   logic [1:0]                 s_axi_bresp,
	output var   logic                       s_axi_bvalid,
	input  wire  logic                       s_axi_bready,
	input  wire  logic [pef_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire  logic                       s_axi_arvalid,
	output var   logic                       s_axi_arready,
	output var   logic [31:0]                s_axi_rdata,
	output var   logic [1:0]                 s_axi_rresp,
	output var   logic                       s_axi_rvalid,
	input  wire  logic                       s_axi_rready,
	input  wire  logic                       saturation_detect,
	input  wire  logic                       overtemp,
	input  wire  logic                       output_overvolt,
	input  wire  logic                       gate_supply_low,
	input  wire  logic                       input_overvolt,
	input  wire  logic                       input_undervolt,
	input  wire  logic                       core_irq_take,
	input  wire  logic [PC_W-1:0]            core_return_pc,
	input  wire  logic                       core_return,
	output var   logic                       irq
);
	import pef_pkg::*;

	localparam int SP_W = $clog2(STK_D);

	typedef struct packed {
		logic [5:0]                  s1;
		logic [5:0]                  s2;
		logic [5:0]                  prev;
		logic [7:0]                  flags;
		logic [7:0]                  enable;
		logic [5:0]                  sel;
		logic [1:0]                  gates;
		logic [STK_D-1:0][PC_W-1:0]  stack;
		logic [SP_W-1:0]             sp;
		logic [MEM_D-1:0][7:0]       mem;
		logic                        awready;
		logic                        wready;
		logic                        bvalid;
		logic [1:0]                  bresp;
		logic                        arready;
		logic                        rvalid;
		logic [1:0]                  rresp;
		logic [31:0]                 rdata;
		logic                        aw_held;
		logic                        w_held;
		logic [ADDR_W-1:0]           awaddr;
		logic [7:0]                  wbyte;
		logic                        wlane;
		logic                        irq;
	} pef_state_t;

	pef_state_t st_r;
	pef_state_t st_nxt;

	logic [5:0]            rise;
	logic [5:0]            fall;
	logic [7:0]            set_ev;
	logic [ADDR_W-1:0]     waddr;
	logic [MEM_IDX_W-1:0]  widx;
	logic [MEM_IDX_W-1:0]  ridx;
	logic [SP_W-1:0]       top;
	logic                  do_wr;
	logic                  wr_hit;
	logic                  rd_hit;
	logic [31:0]           rd_word;

	assign s_axi_awready = st_r.awready;
	assign s_axi_wready  = st_r.wready;
	assign s_axi_bvalid  = st_r.bvalid;
	assign s_axi_bresp   = st_r.bresp;
	assign s_axi_arready = st_r.arready;
	assign s_axi_rvalid  = st_r.rvalid;
	assign s_axi_rresp   = st_r.rresp;
	assign s_axi_rdata   = st_r.rdata;
	assign irq           = st_r.irq;

	always_comb begin
		st_nxt = st_r;
		rise   = st_r.s2 & ~st_r.prev;
		fall   = ~st_r.s2 & st_r.prev;
		top    = st_r.sp - SP_W'(1);

		// comparator inputs resynchronised, index order matches set_ev build below
		st_nxt.s1   = {saturation_detect, overtemp, output_overvolt,
			gate_supply_low, input_overvolt, input_undervolt};
		st_nxt.s2   = st_r.s1;
		st_nxt.prev = st_r.s2;

		// events never look at enables or gates
		set_ev          = RST_BYTE;
		set_ev[FB_SAT]  = rise[5];
		set_ev[FB_OT]   = rise[4];
		set_ev[FB_OOV]  = (st_r.sel[SB_OOV_R] & rise[3]) |
			(st_r.sel[SB_OOV_F] & fall[3]);
		set_ev[FB_GATE] = rise[2];
		set_ev[FB_IOV]  = (st_r.sel[SB_IOV_R] & rise[1]) |
			(st_r.sel[SB_IOV_F] & fall[1]);
		set_ev[FB_IUV]  = (st_r.sel[SB_IUV_R] & rise[0]) |
			(st_r.sel[SB_IUV_F] & fall[0]);

		// write channel: address and data taken independently
		if (s_axi_awvalid && st_r.awready) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && st_r.wready) begin
			st_nxt.w_held = 1'b1;
			st_nxt.wbyte  = s_axi_wdata[7:0];
			st_nxt.wlane  = s_axi_wstrb[0];
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end

		do_wr  = st_r.aw_held && st_r.w_held && !st_r.bvalid;
		waddr  = st_r.awaddr;
		widx   = waddr[MEM_IDX_LSB +: MEM_IDX_W];
		wr_hit = 1'b1;
		if (do_wr) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held  = 1'b0;
			st_nxt.bvalid  = 1'b1;
			if (waddr == OFF_FLAGS) begin
				// zero clears, one leaves the flag alone
				if (st_r.wlane) begin
					st_nxt.flags = st_r.flags & st_r.wbyte;
				end
			end else if (waddr == OFF_ENABLE) begin
				if (st_r.wlane) begin
					st_nxt.enable = st_r.wbyte & FLAG_IMPL;
				end
			end else if (waddr == OFF_SEL) begin
				if (st_r.wlane) begin
					st_nxt.sel = st_r.wbyte[5:0];
				end
			end else if (waddr == OFF_CTRL) begin
				if (st_r.wlane) begin
					st_nxt.gates = st_r.wbyte[1:0];
				end
			end else if (waddr == OFF_STACK || waddr == OFF_SP) begin
				wr_hit = 1'b1;
			end else if (waddr >= OFF_MEM && waddr < OFF_MEM_END) begin
				// every bank window aliases the same bytes
				if (st_r.wlane) begin
					st_nxt.mem[widx] = st_r.wbyte;
				end
			end else begin
				wr_hit = 1'b0;
			end
			st_nxt.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end

		// set wins over a clear landing in the same cycle
		st_nxt.flags = (st_nxt.flags | set_ev) & FLAG_IMPL;

		st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
		st_nxt.wready  = !st_nxt.w_held && !st_nxt.bvalid;

		// read channel: one outstanding read, data straight from the decode
		ridx    = s_axi_araddr[MEM_IDX_LSB +: MEM_IDX_W];
		rd_hit  = 1'b1;
		rd_word = 32'h0000_0000;
		if (s_axi_araddr == OFF_FLAGS) begin
			rd_word[7:0] = st_r.flags & FLAG_IMPL;
		end else if (s_axi_araddr == OFF_ENABLE) begin
			rd_word[7:0] = st_r.enable;
		end else if (s_axi_araddr == OFF_SEL) begin
			rd_word[5:0] = st_r.sel;
		end else if (s_axi_araddr == OFF_CTRL) begin
			rd_word[1:0] = st_r.gates;
		end else if (s_axi_araddr == OFF_STACK) begin
			rd_word[PC_W-1:0] = st_r.stack[top];
		end else if (s_axi_araddr == OFF_SP) begin
			rd_word[SP_W-1:0] = st_r.sp;
		end else if (s_axi_araddr >= OFF_MEM && s_axi_araddr < OFF_MEM_END) begin
			rd_word[7:0] = st_r.mem[ridx];
		end else begin
			rd_hit = 1'b0;
		end
		if (s_axi_arvalid && st_r.arready) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rdata  = rd_word;
			st_nxt.rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		st_nxt.arready = !st_nxt.rvalid;

		// only the return pc is kept; working and status registers are software's
		if (core_irq_take) begin
			st_nxt.stack[st_r.sp] = core_return_pc;
			st_nxt.sp = st_r.sp + SP_W'(1);
		end else if (core_return) begin
			st_nxt.sp = top;
		end

		// registered request built from the next flags, so it rises on the same edge as the flag
		st_nxt.irq = (|(st_nxt.flags & st_nxt.enable)) &&
			st_nxt.gates[CB_PERIPH] && st_nxt.gates[CB_GLOBAL];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// file: design/pef_unused.sv
// no logic here; the whole block sits in pef_top

// file: verif/pef_chk.sv
// port-level assertions for the protection flag block
// assumes the master offers aw and w together with a full wstrb
`timescale 1ns/1ps
`default_nettype none
module pef_chk
	import pef_pkg::*;
(
	input wire logic              aclk,
	input wire logic              aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic              s_axi_awvalid,
	input wire logic              s_axi_awready,
	input wire logic [31:0]       s_axi_wdata,
	input wire logic              s_axi_wvalid,
	input wire logic              s_axi_wready,
	input wire logic              s_axi_bvalid,
	input wire logic              s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic              s_axi_arvalid,
	input wire logic              s_axi_arready,
	input wire logic [31:0]       s_axi_rdata,
	input wire logic              s_axi_rvalid,
	input wire logic              irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic              wr_take;
	logic [1:0]        gate_r;
	logic [ADDR_W-1:0] ra_r;
	logic [2:0]        age_r;
	assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	// gate shadow runs one edge ahead of the design, hence the three-cycle window
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gate_r <= 2'h0;
			ra_r <= 12'h000;
			age_r <= 3'h0;
		end else begin
			if (wr_take && s_axi_awaddr == OFF_CTRL)
				gate_r <= s_axi_wdata[1:0];
			if (s_axi_arvalid && s_axi_arready)
				ra_r <= s_axi_araddr;
			if (wr_take)
				age_r <= 3'h0;
			else if (age_r != 3'h7)
				age_r <= age_r + 3'h1;
		end
	end
	sequence wr_hs;
		wr_take;
	endsequence
	sequence rd_hs;
		s_axi_arvalid && s_axi_arready;
	endsequence
	wr_resp_a: assert property (wr_hs |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write response timing wrong");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted during response");
	rd_lat_a: assert property (rd_hs |=> s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted during data");
	flag_pad_a: assert property (s_axi_rvalid && ra_r == OFF_FLAGS |->
		s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[6:5] == 2'h0)
		else $error("flag pad bits not zero");
	gate_block_a: assert property ((gate_r != 2'h3) [*3] |-> !irq)
		else $error("irq with gates closed");
	irq_stick_a: assert property ($fell(irq) |-> age_r <= 3'h4)
		else $error("irq fell without a write");
endmodule
bind pef_top pef_chk u_chk (.*);
`default_nettype wire

// file: verif/pef_core.sv
// core model: enters on a rising request, returns once it is cleared
// assumes irq is a registered level on aclk
`timescale 1ns/1ps
`default_nettype none
module pef_core #(
	parameter logic [12:0] RET_PC = 13'h0A5C
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        irq,
	output var  logic        core_irq_take,
	output var  logic [12:0] core_return_pc,
	output var  logic        core_return
);
	logic irq_q;
	assign core_return_pc = RET_PC;
	always_ff @(posedge aclk) begin
		irq_q <= aresetn && irq;
		core_irq_take <= aresetn && irq && !irq_q;
		core_return <= aresetn && !irq && irq_q;
	end
endmodule
`default_nettype wire

// file: verif/protection_event_flags_tb.sv
// self-checking bench for the protection flag block
// assumes the core model and the bound checker sit beside it
`timescale 1ns/1ps
`default_nettype none
module protection_event_flags_tb;
	import pef_pkg::*;
	localparam logic [12:0] RET_PC = 13'h0A5C;
	logic              aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              irq, core_irq_take, core_return, s_axi_rready;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, d;
	logic [3:0]        s_axi_wstrb;
	logic [5:0]        cmp;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic [12:0]       core_return_pc;
	int                errors, tests_run;
	pef_top dut (.*, .saturation_detect(cmp[5]), .overtemp(cmp[4]), .output_overvolt(cmp[3]),
		.gate_supply_low(cmp[2]), .input_overvolt(cmp[1]), .input_undervolt(cmp[0]));
	pef_core #(.RET_PC(RET_PC)) core (.*);
	always #2.5 aclk = ~aclk;
	task summarize;
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// sampled at the falling edge so flop updates have settled
	task automatic till(ref logic s);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (s !== 1'b1 && n < 60);
		if (s !== 1'b1) begin
			errors++;
			summarize();
		end
	endtask
	task wr(input logic [ADDR_W-1:0] a, input logic [7:0] v, output logic [1:0] resp);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		till(s_axi_awready);
		@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		till(s_axi_bvalid);
		resp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		till(s_axi_arready);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		till(s_axi_rvalid);
		v = s_axi_rdata;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task t_flags;
		wr(OFF_SEL, 8'h15, r);
		cmp <= 6'h3F;
		repeat (5) @(posedge aclk);
		rd(OFF_FLAGS, d);
		chk(d, 32'h0000009F);
		wr(OFF_FLAGS, 8'h00, r);
		rd(OFF_FLAGS, d);
		chk(d, 32'h00000000);
		wr(OFF_SEL, 8'h2A, r);
		cmp <= 6'h00;
		repeat (5) @(posedge aclk);
		rd(OFF_FLAGS, d);
		chk(d, 32'h0000000B);
	endtask
	task t_irq;
		wr(OFF_ENABLE, 8'h08, r);
		wr(OFF_CTRL, 8'h01, r);
		repeat (4) @(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		@(posedge aclk);
		wr(OFF_CTRL, 8'h03, r);
		repeat (4) @(negedge aclk);
		chk({31'h0, irq}, 32'h1);
		@(posedge aclk);
		rd(OFF_STACK, d);
		chk(d, {19'h0, RET_PC});
		wr(OFF_FLAGS, 8'h00, r);
		repeat (4) @(negedge aclk);
		chk({31'h0, irq}, 32'h0);
		@(posedge aclk);
	endtask
	task t_mem;
		wr(12'h020, 8'h01, r);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(12'h04C, 8'h5A, r);
		rd(12'h08C, d);
		chk(d, 32'h0000005A);
	endtask
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmp} = 62'h0;
		s_axi_wstrb = 4'hF;
		s_axi_rready = 1'b0;
		errors = 0;
		tests_run = 0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_flags();
		t_irq();
		t_mem();
		summarize();
	end
endmodule
`default_nettype wire
